// *** ppc_pkg.sv ***
// Operation
// R1 - ADC clock select: 000 /2, 001 /8, 010 /32, 100 /4, 101 /16, 110 /64, x11 RC.
// R2 - RC choice comes from separate internal oscillator of at most 500 kHz.
// R3 - Analog select bits 3..0 map to pins 4, 2, 1, 0; one means analog.
// R4 - Analog pin loses digital input, pull-up and change interrupt.
// R5 - Software sets an analog pin's direction bit to input.
// R6 - Pull-up bits 5, 4, 2, 1, 0 enable the matching pin pull-up.
// R7 - Pin pull-ups work only while global pull-up control enables them.
// R8 - Pull-up is off whenever the pin is an output.
// R9 - Pin 3 pull-up follows master clear selection; its register bit reads zero.
// R10 - Crystal modes force pull-up bits 5 and 4 to read one.
// R11 - Change enable bits 5..0 enable each pin's change interrupt; reset zero.
// R12 - Change interrupt reaches the processor only with global interrupt enable set.
// R13 - Crystal modes force change enable bits 5 and 4 to read one.
// R14 - Bits 7 and 6 of pull-up and change registers read zero.
// R15 - Pin 3 is input only: port input, timer one gate, master clear.
// R16 - Pin 2 also serves as edge interrupt and timer zero clock input.
// R17 - Change-enabled pins compare with last-read latch; mismatches set change flag.
// R18 - Mismatch keeps setting flag until port access; latch survives warm resets.
// R19 - Configuration writes reach pin controls on the next clock.
`default_nettype none
package ppc_pkg;
  localparam int          ADDR_W     = 5;
  localparam int          NPIN       = 6;
  localparam logic [4:0]  OFF_ANA    = 5'h00;
  localparam logic [4:0]  OFF_WPU    = 5'h04;
  localparam logic [4:0]  OFF_IOC    = 5'h08;
  localparam logic [4:0]  OFF_PORT   = 5'h0C;
  localparam logic [4:0]  OFF_DIR    = 5'h10;
  localparam logic [4:0]  OFF_CTL    = 5'h14;
  localparam logic [4:0]  OFF_STAT   = 5'h18;
  localparam logic [4:0]  OFF_MASK   = 5'h1C;
  localparam logic [7:0]  RST_ANA    = 8'h0F;
  localparam logic [7:0]  RST_WPU    = 8'h37;
  localparam logic [7:0]  RST_IOC    = 8'h00;
  localparam logic [5:0]  RST_DIR    = 6'h3F;
  localparam logic [2:0]  RST_CTL    = 3'h1;
  localparam logic [7:0]  ANA_IMPL   = 8'h7F;
  localparam logic [7:0]  WPU_IMPL   = 8'h37;
  localparam logic [7:0]  IOC_IMPL   = 8'h3F;
  localparam logic [7:0]  XTAL_FORCE = 8'h30;
  localparam logic [5:0]  DIR_FORCE  = 6'h08;
  localparam int          CTL_GPC    = 0;
  localparam int          CTL_GIE    = 1;
  localparam int          CTL_EDGE   = 2;
  localparam int          STAT_PCF   = 0;
  localparam int          STAT_EXT   = 1;
  localparam int          NSTAT      = 2;
  localparam int          PIN_MASTER_CLEAR_INPUT   = 3;
  localparam int          PIN_EXT    = 2;
  localparam int          ADC_CLOCK_SELECT_LSB   = 4;
  localparam int          DIV_W      = 7;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          CLK_KHZ    = 10000;
  localparam int          RC_MAX_KHZ = 500;
  // RC ticks must be slow enough to survive the three-stage pin sampler
  localparam int          RC_MIN_CYC = CLK_KHZ / RC_MAX_KHZ;

  // Analog bits to pin positions: 3->4, 2->2, 1->1, 0->0
  function automatic logic [5:0] ppc_ana_mask(input logic [3:0] analog_select_bits);
    ppc_ana_mask = {1'b0, analog_select_bits[3], 1'b0, analog_select_bits[2], analog_select_bits[1], analog_select_bits[0]};
  endfunction : ppc_ana_mask

  // Divide ratio for the converter clock; zero means RC source
  function automatic logic [6:0] ppc_adc_div(input logic [2:0] sel);
    case (sel)
      3'h0:    ppc_adc_div = 7'h02;
      3'h1:    ppc_adc_div = 7'h08;
      3'h2:    ppc_adc_div = 7'h20;
      3'h4:    ppc_adc_div = 7'h04;
      3'h5:    ppc_adc_div = 7'h10;
      3'h6:    ppc_adc_div = 7'h40;
      default: ppc_adc_div = 7'h00;
    endcase
  endfunction : ppc_adc_div
endpackage : ppc_pkg
`default_nettype wire

// *** ppc_sync3.sv ***
`default_nettype none
module ppc_sync3 #(
  parameter int W = 1
) (
  input  wire logic         aclk,   // System clock
  input  wire logic         aresetn, // Sync reset, low active
  input  wire logic         ce,     // Clock enable
  input  wire logic [W-1:0] d,      // Asynchronous inputs
  output logic      [W-1:0] q       // Filtered level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end
endmodule : ppc_sync3
`default_nettype wire

// *** ppc_port_cfg.sv ***
`default_nettype none
module ppc_port_cfg (
  input  wire logic        aclk,          // System clock
  input  wire logic        aresetn,       // Power-on reset, low active
  input  wire logic        ce,            // Clock enable
  input  wire logic        warm_rst,      // Master clear or brown-out reset
  input  wire logic        cfg_master_clear_input_en,   // Config word: pin 3 is master clear
  input  wire logic        cfg_xtal_mode, // Config word: crystal oscillator
  input  wire logic        rc_osc_i,      // Dedicated RC oscillator
  input  wire logic [5:0]  pin_i,         // Pin levels
  output logic      [5:0]  pin_o,         // Pin output data
  output logic      [5:0]  pin_oe_n,      // Low while driving
  output logic      [5:0]  pullup_en,     // Weak pull-up on
  output logic      [5:0]  analog_en,     // Pin routed to analog
  output logic             adc_rc_sel,    // Converter on RC clock
  output logic             adc_clk_tick,  // Converter clock pulse
  output logic             tmr0_clk,      // Timer zero clock input level
  output logic             tmr1_gate,     // Timer one gate level
  output logic             master_clear_input_req,      // Master clear asserted
  output logic             irq,           // Interrupt, level
  input  wire logic [4:0]  s_axi_awaddr,  // AXI write address
  input  wire logic        s_axi_awvalid, // AXI
  output logic             s_axi_awready, // AXI
  input  wire logic [31:0] s_axi_wdata,   // AXI write data
  input  wire logic [3:0]  s_axi_wstrb,   // AXI byte strobes
  input  wire logic        s_axi_wvalid,  // AXI
  output logic             s_axi_wready,  // AXI
  output logic [1:0]       s_axi_bresp,   // AXI
  output logic             s_axi_bvalid,  // AXI
  input  wire logic        s_axi_bready,  // AXI
  input  wire logic [4:0]  s_axi_araddr,  // AXI read address
  input  wire logic        s_axi_arvalid, // AXI
  output logic             s_axi_arready, // AXI
  output logic [31:0]      s_axi_rdata,   // AXI read data
  output logic [1:0]       s_axi_rresp,   // AXI
  output logic             s_axi_rvalid,  // AXI
  input  wire logic        s_axi_rready   // AXI
);
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] ana_q;
  logic [7:0] wpu_q;
  logic [7:0] ioc_q;
  logic [5:0] dir_q;
  logic [5:0] out_q;
  logic [2:0] ctl_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [5:0] last_q;
  logic [4:0] awaddr_q;
  logic [7:0] wdata_q;
  logic       aw_q;
  logic       w_q;
  logic       wstrb_q;
  logic [6:0] div_cnt_q;
  logic       rc_q;
  logic       ext_q;
  logic [6:0] pins_s;
  logic [5:0] ana_m;
  logic [5:0] dig_in;
  logic       wr_go;
  logic       rd_go;
  logic       port_rd;
  logic       port_wr;
  logic       mismatch;
  logic       ext_evt;
  logic [6:0] div;
  logic [7:0] rd_val;
  logic       rd_hit;

  ppc_sync3 #(.W(7)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .d       ({rc_osc_i, pin_i}),
    .q       (pins_s)
  );

  assign ana_m  = ppc_pkg::ppc_ana_mask(ana_q[3:0]); // R3
  assign dig_in = pins_s[5:0] & ~ana_m; // R4

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: address and data taken in either order
  assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign wr_go   = aw_q & w_q & ~s_axi_bvalid;
  assign rd_go   = s_axi_arvalid & s_axi_arready;
  assign port_rd = rd_go && s_axi_araddr == ppc_pkg::OFF_PORT;
  assign port_wr = wr_go && wstrb_q && awaddr_q == ppc_pkg::OFF_PORT;

  always_ff @(posedge aclk) begin
    if (!aresetn || warm_rst) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || warm_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ppc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        case (awaddr_q)
          ppc_pkg::OFF_ANA, ppc_pkg::OFF_WPU, ppc_pkg::OFF_IOC,
          ppc_pkg::OFF_PORT, ppc_pkg::OFF_DIR, ppc_pkg::OFF_CTL,
          ppc_pkg::OFF_STAT, ppc_pkg::OFF_MASK: s_axi_bresp <= ppc_pkg::RESP_OKAY;
          default: s_axi_bresp <= ppc_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers; new values drive pins from the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn || warm_rst) begin
      ana_q  <= ppc_pkg::RST_ANA;
      wpu_q  <= ppc_pkg::RST_WPU;
      ioc_q  <= ppc_pkg::RST_IOC; // R11
      dir_q  <= ppc_pkg::RST_DIR;
      out_q  <= '0;
      ctl_q  <= ppc_pkg::RST_CTL;
      mask_q <= '0;
    end else if (ce && wr_go && wstrb_q) begin // R19
      case (awaddr_q)
        ppc_pkg::OFF_ANA:  ana_q  <= wdata_q & ppc_pkg::ANA_IMPL;
        ppc_pkg::OFF_WPU:  wpu_q  <= wdata_q & ppc_pkg::WPU_IMPL;
        ppc_pkg::OFF_IOC:  ioc_q  <= wdata_q & ppc_pkg::IOC_IMPL;
        ppc_pkg::OFF_PORT: out_q  <= wdata_q[5:0];
        ppc_pkg::OFF_DIR:  dir_q  <= wdata_q[5:0] | ppc_pkg::DIR_FORCE; // R15
        ppc_pkg::OFF_CTL:  ctl_q  <= wdata_q[2:0];
        ppc_pkg::OFF_MASK: mask_q <= wdata_q[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Last-read latch: only power-on clears it, warm resets leave it alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_q <= '0;
    end else if (ce && (port_rd || port_wr)) begin // R18
      last_q <= dig_in;
    end
  end

  assign mismatch = |((dig_in ^ last_q) & ioc_q[5:0] & ~ana_m); // R17 R4

  // Pin 2 edge interrupt, polarity from control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_q <= 1'b0;
    end else if (ce) begin
      ext_q <= dig_in[ppc_pkg::PIN_EXT];
    end
  end
  assign ext_evt = ctl_q[ppc_pkg::CTL_EDGE]
                 ? (dig_in[ppc_pkg::PIN_EXT] & ~ext_q)
                 : (~dig_in[ppc_pkg::PIN_EXT] & ext_q); // R16

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn || warm_rst) begin
      stat_q <= '0;
    end else if (ce) begin
      for (int i = 0; i < ppc_pkg::NSTAT; i++) begin
        if ((i == ppc_pkg::STAT_PCF && mismatch) || (i == ppc_pkg::STAT_EXT && ext_evt)) begin
          stat_q[i] <= 1'b1; // R18
        end else if (wr_go && wstrb_q && awaddr_q == ppc_pkg::OFF_STAT && wdata_q[i]) begin
          stat_q[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = ctl_q[ppc_pkg::CTL_GIE] & |(stat_q & mask_q); // R12

  ////////////////////////////////////////////////////////////////////////
  // Read mux with forced read values
  always_comb begin
    rd_hit = 1'b1;
    rd_val = '0;
    case (s_axi_araddr)
      ppc_pkg::OFF_ANA: rd_val = ana_q & ppc_pkg::ANA_IMPL;
      ppc_pkg::OFF_WPU: begin
        rd_val = wpu_q & ppc_pkg::WPU_IMPL; // R9 R14
        if (cfg_xtal_mode) begin
          rd_val = rd_val | ppc_pkg::XTAL_FORCE; // R10
        end
      end
      ppc_pkg::OFF_IOC: begin
        rd_val = ioc_q & ppc_pkg::IOC_IMPL; // R14
        if (cfg_xtal_mode) begin
          rd_val = rd_val | ppc_pkg::XTAL_FORCE; // R13
        end
      end
      ppc_pkg::OFF_PORT: rd_val = {2'b00, dig_in};
      ppc_pkg::OFF_DIR: begin
        rd_val = {2'b00, dir_q};
        if (cfg_xtal_mode) begin
          rd_val = rd_val | ppc_pkg::XTAL_FORCE;
        end
      end
      ppc_pkg::OFF_CTL:  rd_val = {5'b00000, ctl_q};
      ppc_pkg::OFF_STAT: rd_val = {6'b000000, stat_q};
      ppc_pkg::OFF_MASK: rd_val = {6'b000000, mask_q};
      default:           rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || warm_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= ppc_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_val};
        s_axi_rresp  <= rd_hit ? ppc_pkg::RESP_OKAY : ppc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin control; software keeps analog pins as inputs (R5)
  always_ff @(posedge aclk) begin
    if (!aresetn || warm_rst) begin
      pin_o     <= '0;
      pin_oe_n  <= '1;
      pullup_en <= '0;
      analog_en <= '0;
      tmr0_clk  <= 1'b0;
      tmr1_gate <= 1'b0;
      master_clear_input_req  <= 1'b0;
    end else if (ce) begin
      pin_o     <= out_q;
      pin_oe_n  <= dir_q | ppc_pkg::DIR_FORCE; // R15
      analog_en <= ana_m; // R3
      for (int i = 0; i < ppc_pkg::NPIN; i++) begin
        if (i == ppc_pkg::PIN_MASTER_CLEAR_INPUT) begin
          pullup_en[i] <= cfg_master_clear_input_en; // R9
        end else begin
          pullup_en[i] <= wpu_q[i] & ~ctl_q[ppc_pkg::CTL_GPC] & dir_q[i] & ~ana_m[i]; // R6 R7 R8 R4
        end
      end
      tmr0_clk  <= dig_in[ppc_pkg::PIN_EXT]; // R16
      tmr1_gate <= ~cfg_master_clear_input_en & dig_in[ppc_pkg::PIN_MASTER_CLEAR_INPUT]; // R15
      master_clear_input_req  <= cfg_master_clear_input_en & ~dig_in[ppc_pkg::PIN_MASTER_CLEAR_INPUT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Converter clock: system divider or the synchronised RC oscillator
  assign div        = ppc_pkg::ppc_adc_div(ana_q[ppc_pkg::ADC_CLOCK_SELECT_LSB +: 3]); // R1
  assign adc_rc_sel = (div == '0); // R2

  always_ff @(posedge aclk) begin
    if (!aresetn || warm_rst) begin
      div_cnt_q    <= '0;
      rc_q         <= 1'b0;
      adc_clk_tick <= 1'b0;
    end else if (ce) begin
      rc_q <= pins_s[ppc_pkg::NPIN];
      if (adc_rc_sel) begin
        div_cnt_q    <= '0;
        adc_clk_tick <= pins_s[ppc_pkg::NPIN] & ~rc_q; // R2
      end else if (div_cnt_q >= div - 7'h01) begin
        div_cnt_q    <= '0;
        adc_clk_tick <= 1'b1; // R1
      end else begin
        div_cnt_q    <= div_cnt_q + 7'h01;
        adc_clk_tick <= 1'b0;
      end
    end
  end
endmodule : ppc_port_cfg
`default_nettype wire

// *** ppc_port_cfg_asserts.sv ***
`default_nettype none
module ppc_port_cfg_asserts (
  input wire logic        aclk,         // Clock
  input wire logic        aresetn,      // Reset
  input wire logic        ce,           // Enable
  input wire logic        warm_rst,     // Warm reset
  input wire logic        cfg_master_clear_input_en,  // Master clear mode
  input wire logic [5:0]  pin_oe_n,     // Drive off
  input wire logic [5:0]  pullup_en,    // Pull-ups
  input wire logic [5:0]  analog_en,    // Analog
  input wire logic        adc_clk_tick, // Tick
  input wire logic        master_clear_input_req,     // Master clear
  input wire logic        tmr1_gate,    // Gate
  input wire logic [31:0] s_axi_rdata,  // Read data
  input wire logic        s_axi_rvalid  // Read valid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  // Warm reset clears outputs, so registered relations skip it
  sequence s_run;
    ce && !warm_rst;
  endsequence
  sequence s_run2;
    s_run ##1 s_run;
  endsequence
  chk_master_clear_input_pullup: assert property (s_run2 |-> pullup_en[3] == $past(cfg_master_clear_input_en))
    else $error("pin 3 pull-up wrong");
  chk_analog_pullup: assert property ((pullup_en & analog_en) == 6'h00)
    else $error("pull-up on analog pin");
  chk_output_pullup: assert property ((pullup_en & ~pin_oe_n) == 6'h00)
    else $error("pull-up on output pin");
  chk_pin3_input: assert property (pin_oe_n[3])
    else $error("pin 3 driven");
  chk_analog_map: assert property ({analog_en[5], analog_en[3]} == 2'b00)
    else $error("analog on unselectable pin");
  chk_tick_pulse: assert property (adc_clk_tick |=> !adc_clk_tick)
    else $error("converter tick too long");
  chk_master_clear_input_mode: assert property (master_clear_input_req |-> $past(cfg_master_clear_input_en))
    else $error("master clear while pin 3 is port");
  chk_gate_master_clear_input: assert property (tmr1_gate |-> !$past(cfg_master_clear_input_en))
    else $error("gate live in master clear mode");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
endmodule : ppc_port_cfg_asserts
bind ppc_port_cfg ppc_port_cfg_asserts u_chk (.*);
`default_nettype wire

// *** ppc_pins_model.sv ***
`default_nettype none
module ppc_pins_model (
  input  wire logic       aclk,      // Clock
  input  wire logic [5:0] ext_en,    // Tester drives pin
  input  wire logic [5:0] ext_val,   // Tester level
  input  wire logic [5:0] pin_o,     // Device data
  input  wire logic [5:0] pin_oe_n,  // Device drive off
  input  wire logic [5:0] pullup_en, // Weak pull-up
  output logic      [5:0] pin_i      // Resolved wire
);
  timeunit 1ns;
  timeprecision 1ns;
  // Floating pins toggle so an unknown never settles by luck
  logic [5:0] float_q = 6'h15;
  always_ff @(posedge aclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (!pin_oe_n[i]) pin_i[i] = pin_o[i];
      else if (ext_en[i]) pin_i[i] = ext_val[i];
      else if (pullup_en[i]) pin_i[i] = 1'b1;
      else pin_i[i] = float_q[i];
    end
  end
endmodule : ppc_pins_model
`default_nettype wire

// *** ppc_port_cfg_tb.sv ***
`default_nettype none
module ppc_port_cfg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, warm_rst = 1'b0, rc_osc_i = 1'b0;
  logic        cfg_master_clear_input_en = 1'b0, cfg_xtal_mode = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, adc_rc_sel, adc_clk_tick, tmr0_clk, tmr1_gate;
  logic        master_clear_input_req, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, rd_q;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [5:0]  ext_en = 6'h00, ext_val = 6'h00, pin_i, pin_o, pin_oe_n, pullup_en;
  logic [5:0]  analog_en, am, pu;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp_q;
  logic [7:0]  m [8];
  int          err_count = 0, checks_done = 0, seed = 32'h3849, g;
  int          ix [6] = '{0, 1, 2, 4, 5, 7};
  int          dv [8] = '{2, 8, 32, 0, 4, 16, 64, 0};
  ppc_port_cfg uut (.*);
  ppc_pins_model u_pins (.*);
  always #50 aclk = ~aclk;
  // RC period of 30 cycles stays under the 500 kHz ceiling
  always begin
    repeat (15) @(posedge aclk);
    rc_osc_i <= ~rc_osc_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // Handshakes are judged on values settled at the falling edge, which
  // are exactly what the next rising edge samples; avoids edge races
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int   n;
    logic a_ok;
    logic w_ok;
    logic b_ok;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      a_ok = s_axi_awvalid & s_axi_awready;
      w_ok = s_axi_wvalid & s_axi_wready;
      b_ok = (s_axi_bvalid === 1'b1);
      rsp_q = s_axi_bresp;
      @(posedge aclk);
      n++;
      if (a_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end while (!b_ok && n < 100);
    s_axi_bready <= 1'b0;
    if (!b_ok) err_count++;
    m[a[4:2]] = d;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    int   n;
    logic a_ok;
    logic r_ok;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      a_ok = s_axi_arvalid & s_axi_arready;
      r_ok = (s_axi_rvalid === 1'b1);
      rd_q = s_axi_rdata;
      rsp_q = s_axi_rresp;
      @(posedge aclk);
      n++;
      if (a_ok) s_axi_arvalid <= 1'b0;
    end while (!r_ok && n < 100);
    s_axi_rready <= 1'b0;
    if (!r_ok) err_count++;
  endtask : rd
  // Cycles up to the next converter tick, sampled mid-cycle
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge aclk);
      c++;
    end while (adc_clk_tick !== 1'b1 && c < 300);
  endtask : gap
  function automatic logic [31:0] exp_rd(input int i);
    logic [7:0] x;
    x = cfg_xtal_mode ? 8'h30 : 8'h00;
    case (i)
      0: exp_rd = {24'h0, m[0] & 8'h7F};
      1: exp_rd = {24'h0, m[1] & 8'h37 | x};
      2: exp_rd = {24'h0, m[2] & 8'h3F | x};
      4: exp_rd = {24'h0, m[4] & 8'h3F | 8'h08 | x};
      5: exp_rd = {24'h0, m[5] & 8'h07};
      default: exp_rd = {24'h0, m[7] & 8'h03};
    endcase
  endfunction : exp_rd
  ////////////////////////////////////////////////////////////
  initial begin
    m = '{8'h0F, 8'h37, 8'h00, 8'h00, 8'h3F, 8'h01, 8'h00, 8'h00};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ix[k]) begin
      rd(5'(ix[k] * 4));
      chk(rd_q, exp_rd(ix[k]));
    end
    rd(5'h02);
    chk({rd_q[29:0], rsp_q}, {30'h0, ppc_pkg::RESP_SLVERR});
    for (int p = 0; p < 2; p++) begin
      cfg_xtal_mode <= p[0];
      foreach (ix[k]) wr(5'(ix[k] * 4), 8'($random(seed)));
      foreach (ix[k]) begin
        rd(5'(ix[k] * 4));
        chk(rd_q, exp_rd(ix[k]));
      end
    end
    $display("test registers done");
    repeat (8) begin
      cfg_master_clear_input_en <= 1'($random(seed));
      for (int i = 0; i < 6; i++) if (i != 3) wr(5'(i * 4), 8'($random(seed)));
      repeat (2) @(posedge aclk);
      am = {1'b0, m[0][3], 1'b0, m[0][2:0]};
      pu = m[1][5:0] & 6'h37 & m[4][5:0] & ~am & {6{~m[5][0]}} | {2'b0, cfg_master_clear_input_en, 3'b0};
      chk(analog_en, am);
      chk(pullup_en, pu);
      chk(pin_oe_n, m[4][5:0] | 6'h08);
    end
    $display("test pin config done");
    for (int s = 0; s < 8; s++) begin
      wr(5'h00, {1'b0, 3'(s), 4'h0});
      gap(g);
      gap(g);
      chk(g, (s % 4 == 3) ? 30 : dv[s]);
      chk(adc_rc_sel, s % 4 == 3);
    end
    $display("test converter clock done");
    ext_en <= 6'h3F;
    wr(5'h10, 8'h3F);
    wr(5'h08, 8'h01);
    wr(5'h1C, 8'h01);
    wr(5'h14, 8'h02);
    rd(5'h0C);
    wr(5'h18, 8'h03);
    repeat (8) @(posedge aclk);
    chk(irq, 1'b0);
    ext_val <= 6'h01;
    repeat (8) @(posedge aclk);
    chk(irq, 1'b1);
    // Clearing without a port read must not stick while mismatch lasts
    wr(5'h18, 8'h01);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    rd(5'h0C);
    chk(rd_q, 32'h00000001);
    wr(5'h18, 8'h01);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    ext_val <= 6'h00;
    warm_rst <= 1'b1;
    @(posedge aclk);
    warm_rst <= 1'b0;
    wr(5'h00, 8'h00);
    wr(5'h08, 8'h01);
    wr(5'h1C, 8'h01);
    wr(5'h14, 8'h02);
    repeat (8) @(posedge aclk);
    chk(irq, 1'b1);
    wr(5'h14, 8'h00);
    chk(irq, 1'b0);
    $display("test change interrupt done");
    rd(5'h0C);
    wr(5'h18, 8'h03);
    wr(5'h14, 8'h02);
    wr(5'h00, 8'h01);
    ext_val <= 6'h01;
    repeat (8) @(posedge aclk);
    chk(irq, 1'b0);
    rd(5'h0C);
    chk(rd_q, 32'h00000000);
    for (int v = 0; v < 2; v++) begin
      cfg_master_clear_input_en <= !v[0];
      ext_val <= {6{v[0]}};
      repeat (8) @(posedge aclk);
      chk(master_clear_input_req, !v[0]);
      chk(tmr1_gate, v[0]);
      chk(tmr0_clk, v[0]);
    end
    $display("test pin functions done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    conclude();
  end
endmodule : ppc_port_cfg_tb
`default_nettype wire
